/* logic/chan_trim_regs.sv */
// Channel three trim registers and channel four input setup register
`timescale 1ns/1ps
`default_nettype none
module chan_trim_regs (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    input wire logic mod_tick,
    input wire logic ch3_mod_bit,
    output logic ch3_mod_bit_delayed,
    output logic [3:0] gain_trim_code,
    output logic signed [3:0] gain_trim_tenth_db,
    output logic [7:0] phase_delay_cycles,
    output logic input_kind_select,
    output logic [1:0] input_source_select,
    output logic coupling_select,
    output logic mic_swing_select,
    output logic [1:0] amp_rejection_mode,
    output logic auto_gain_enable
);
    import chan_trim_pkg::*;

    logic [3:0] gain_trim_q;
    logic signed [3:0] gain_tenth_q;
    logic [7:0] phase_trim_q;
    logic [7:0] setup_q;
    logic [7:0] rdata_q;
    logic wr_gain;
    logic wr_phase;
    logic wr_setup;

    // ************************************************************
    // Write decode
    // ************************************************************
    assign wr_gain = reg_wr_en && (reg_addr == GAIN_TRIM_OFS);
    assign wr_phase = reg_wr_en && (reg_addr == PHASE_TRIM_OFS);
    assign wr_setup = reg_wr_en && (reg_addr == INPUT_SETUP_OFS);

    // Returns the trim in tenths of a dB: code minus the zero-trim code
    function automatic logic signed [3:0] trim_tenths(input logic [3:0] code);
        trim_tenths = signed'(code - GAIN_TRIM_ZERO_CODE);
    endfunction

    // ************************************************************
    // Channel three trims
    // ************************************************************
    // Only the upper nibble is stored; the low nibble has no flops at all
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gain_trim_q <= GAIN_TRIM_RST;
            // Constant operands only, so the reset branch carries no logic
            gain_tenth_q <= signed'(GAIN_TRIM_RST - GAIN_TRIM_ZERO_CODE);
        end else if (wr_gain) begin
            gain_trim_q <= reg_wdata[GAIN_TRIM_MSB:GAIN_TRIM_LSB];
            gain_tenth_q <= trim_tenths(reg_wdata[GAIN_TRIM_MSB:GAIN_TRIM_LSB]);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_trim_q <= PHASE_TRIM_RST;
        end else if (wr_phase) begin
            phase_trim_q <= reg_wdata;
        end
    end

    // ************************************************************
    // Channel four input setup
    // ************************************************************
    // Reserved codes are stored as written; keeping them out is the host's job
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            setup_q <= INPUT_SETUP_RST;
        end else if (wr_setup) begin
            setup_q <= reg_wdata;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // A write in the same cycle as a read shows up on the next read, not this one
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= UNMAPPED_RD;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                GAIN_TRIM_OFS: rdata_q <= {gain_trim_q, GAIN_TRIM_RSVD_RD};
                PHASE_TRIM_OFS: rdata_q <= phase_trim_q;
                INPUT_SETUP_OFS: rdata_q <= setup_q;
                default: rdata_q <= UNMAPPED_RD;
            endcase
        end
    end

    // ************************************************************
    // Channel three phase delay
    // ************************************************************
    // Full 255-tap history; a shallower build would clip the largest trims
    phase_delay_line #(
        .DEPTH(PHASE_DEPTH)
    ) u_delay (
        .mclk(mclk),
        .nrst(nrst),
        .mod_tick(mod_tick),
        .phase_delay_cycles(phase_trim_q),
        .bit_in(ch3_mod_bit),
        .bit_out(ch3_mod_bit_delayed)
    );

    assign reg_rdata = rdata_q;
    assign gain_trim_code = gain_trim_q;
    assign gain_trim_tenth_db = gain_tenth_q;
    assign phase_delay_cycles = phase_trim_q;
    assign input_kind_select = setup_q[KIND_BIT];
    assign input_source_select = setup_q[SRC_MSB:SRC_LSB];
    assign coupling_select = setup_q[COUPLE_BIT];
    assign mic_swing_select = setup_q[SWING_BIT];
    assign amp_rejection_mode = setup_q[AMP_MSB:AMP_LSB];
    // The controller itself reads its mode from register 108 elsewhere
    assign auto_gain_enable = setup_q[AGC_BIT];

    // ************************************************************
    // Checks
    // ************************************************************
    a_gain_trim_write: assert property (@(posedge mclk) disable iff (!nrst)
        wr_gain |=> gain_trim_code == $past(reg_wdata[7:4]))
        else $error("gain trim code did not take the written upper nibble");

    a_trim_tenths_map: assert property (@(posedge mclk) disable iff (!nrst)
        (5'(gain_trim_code) == 5'(gain_trim_tenth_db) + 5'h08))
        else $error("gain trim offset is not code minus eight");

    a_rsvd_reads_zero: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd_en && reg_addr == 8'h49 |=> reg_rdata == {$past(gain_trim_q), 4'h0})
        else $error("gain trim read returned wrong data or nonzero reserved bits");

    a_phase_write: assert property (@(posedge mclk) disable iff (!nrst)
        reg_wr_en && reg_addr == 8'h4A |=> phase_delay_cycles == $past(reg_wdata))
        else $error("phase trim did not take the written value");

    a_setup_fields: assert property (@(posedge mclk) disable iff (!nrst)
        wr_setup |=> input_kind_select == $past(reg_wdata[7])
        && coupling_select == $past(reg_wdata[4])
        && auto_gain_enable == $past(reg_wdata[0])
        && amp_rejection_mode == $past(reg_wdata[2:1]))
        else $error("input setup fields do not follow the written byte");

    a_fields_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !reg_wr_en |=> $stable(phase_delay_cycles) && $stable(gain_trim_code)
        && $stable({input_kind_select, input_source_select, coupling_select}))
        else $error("a configuration field changed without a write");

    a_setup_readback: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd_en && reg_addr == 8'h4B |=> reg_rdata == $past({input_kind_select,
        input_source_select, coupling_select, mic_swing_select,
        amp_rejection_mode, auto_gain_enable}))
        else $error("input setup read does not match the live fields");

    a_unmapped_zero: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd_en && (reg_addr < 8'h49 || reg_addr > 8'h4B) |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");

    a_phase_readback: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd_en && reg_addr == PHASE_TRIM_OFS |=> reg_rdata == $past(phase_trim_q))
        else $error("phase trim read does not match the stored delay");

    // Read data is registered and must not drift between reads
    a_rdata_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !reg_rd_en |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_gain_own_write: assert property (@(posedge mclk) disable iff (!nrst)
        !wr_gain |=> $stable(gain_trim_code) && $stable(gain_trim_tenth_db))
        else $error("gain trim changed without a write to its own address");

    a_phase_own_write: assert property (@(posedge mclk) disable iff (!nrst)
        !wr_phase |=> $stable(phase_delay_cycles))
        else $error("phase trim changed without a write to its own address");

    // Writes to the channel three trims must leave the channel four setup alone
    a_setup_own_write: assert property (@(posedge mclk) disable iff (!nrst)
        !wr_setup |=> $stable({input_kind_select, input_source_select,
        coupling_select, mic_swing_select, amp_rejection_mode, auto_gain_enable}))
        else $error("input setup changed without a write to its own address");

    a_swing_source: assert property (@(posedge mclk) disable iff (!nrst)
        wr_setup |=> mic_swing_select == $past(reg_wdata[3])
        && input_source_select == $past(reg_wdata[6:5]))
        else $error("swing or source field does not follow the written byte");

    // Codes below the zero-trim code must give a negative trim
    a_trim_sign: assert property (@(posedge mclk) disable iff (!nrst)
        gain_trim_tenth_db[3] == !gain_trim_code[3])
        else $error("gain trim sign does not match the code");

    c_agc_on_ac: cover property (@(posedge mclk) disable iff (!nrst)
        wr_setup && reg_wdata[0] && !reg_wdata[4]);
    c_phase_nonzero: cover property (@(posedge mclk) disable iff (!nrst)
        wr_phase ##1 phase_delay_cycles != 8'h00 ##[1:20] mod_tick);
    c_trim_readback: cover property (@(posedge mclk) disable iff (!nrst)
        wr_gain ##[1:4] (reg_rd_en && reg_addr == GAIN_TRIM_OFS));
endmodule
`default_nettype wire

/* logic/chan_trim_pkg.sv */
// Offsets, field layouts and reset values of the channel trim and input setup registers
package chan_trim_pkg;
    localparam logic [7:0] GAIN_TRIM_OFS = 8'h49;
    localparam logic [7:0] PHASE_TRIM_OFS = 8'h4A;
    localparam logic [7:0] INPUT_SETUP_OFS = 8'h4B;

    localparam logic [3:0] GAIN_TRIM_RST = 4'h8;
    localparam logic [3:0] GAIN_TRIM_ZERO_CODE = 4'h8;
    localparam int GAIN_TRIM_MSB = 7;
    localparam int GAIN_TRIM_LSB = 4;
    localparam logic [3:0] GAIN_TRIM_RSVD_RD = 4'h0;

    localparam logic [7:0] PHASE_TRIM_RST = 8'h00;
    localparam int PHASE_DEPTH = 255;

    localparam logic [7:0] INPUT_SETUP_RST = 8'h10;
    localparam int KIND_BIT = 7;
    localparam int SRC_MSB = 6;
    localparam int SRC_LSB = 5;
    localparam int COUPLE_BIT = 4;
    localparam int SWING_BIT = 3;
    localparam int AMP_MSB = 2;
    localparam int AMP_LSB = 1;
    localparam int AGC_BIT = 0;

    localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage

/* logic/phase_delay_line.sv */
// Programmable delay of a modulator bit stream in whole modulator clock cycles
`timescale 1ns/1ps
`default_nettype none
module phase_delay_line #(
    parameter int DEPTH = 255
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic mod_tick,
    input wire logic [7:0] phase_delay_cycles,
    input wire logic bit_in,
    output logic bit_out
);
    logic [DEPTH-1:0] hist_q;
    logic bit_out_q;

    // hist_q[k] holds the bit taken k+1 modulator ticks ago
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hist_q <= '0;
        end else if (mod_tick) begin
            hist_q <= {hist_q[DEPTH-2:0], bit_in};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bit_out_q <= 1'b0;
        end else if (mod_tick) begin
            if (phase_delay_cycles == 8'h00) begin
                bit_out_q <= bit_in;
            end else begin
                bit_out_q <= hist_q[phase_delay_cycles - 8'h01];
            end
        end
    end

    assign bit_out = bit_out_q;

    a_zero_delay_pass: assert property (@(posedge mclk) disable iff (!nrst)
        mod_tick && phase_delay_cycles == 8'h00 |=> bit_out == $past(bit_in))
        else $error("zero phase delay did not pass the bit straight through");

    a_two_delay_hold: assert property (@(posedge mclk) disable iff (!nrst)
        mod_tick && phase_delay_cycles == 8'h02 |=> bit_out == $past(hist_q[1]))
        else $error("two cycle phase delay picked the wrong history bit");

    c_long_delay: cover property (@(posedge mclk) disable iff (!nrst)
        mod_tick && phase_delay_cycles == 8'hFF);
endmodule
`default_nettype wire

/* dv/chan_trim_regs_bench.sv */
// Self-checking bench of the channel trim and input setup registers
`timescale 1ns/1ps
`default_nettype none
module chan_trim_regs_bench;
    import chan_trim_pkg::*;
    logic mclk, nrst, reg_wr_en, reg_rd_en, mod_tick, ch3_mod_bit, ch3_mod_bit_delayed;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, phase_delay_cycles;
    logic [3:0] gain_trim_code;
    logic signed [3:0] gain_trim_tenth_db;
    logic input_kind_select, coupling_select, mic_swing_select, auto_gain_enable;
    logic [1:0] input_source_select, amp_rejection_mode;
    int fails = 0;
    int num_checks = 0;
    logic [7:0] setup_vals [0:6] = '{8'h80, 8'h20, 8'h08, 8'h04, 8'h01, 8'hA5, 8'h10};
    logic [3:0] gain_vals [0:3] = '{4'h0, 4'h8, 4'hF, 4'h5};
    // Trim in tenths of a dB for each code above: -8, 0, +7, -3
    logic [3:0] gain_tenths [0:3] = '{4'h8, 4'h0, 4'h7, 4'hD};

    chan_trim_regs chan_trim_regs_i (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata), .mod_tick(mod_tick), .ch3_mod_bit(ch3_mod_bit),
        .ch3_mod_bit_delayed(ch3_mod_bit_delayed), .gain_trim_code(gain_trim_code),
        .gain_trim_tenth_db(gain_trim_tenth_db), .phase_delay_cycles(phase_delay_cycles),
        .input_kind_select(input_kind_select), .input_source_select(input_source_select),
        .coupling_select(coupling_select), .mic_swing_select(mic_swing_select),
        .amp_rejection_mode(amp_rejection_mode), .auto_gain_enable(auto_gain_enable));

    // ****************************************
    // Clock, access tasks and checking
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe is dropped and an edge passes, so back-to-back calls never collide
    task wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr_en <= 1'b1;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        #1;
    endtask

    task rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk);
        reg_addr <= addr;
        reg_rd_en <= 1'b1;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    task conclude;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task check_defaults;
        logic [7:0] v;
        rd(8'h49, v);
        chk(v, 8'h80);
        rd(8'h4A, v);
        chk(v, 8'h00);
        rd(8'h4B, v);
        chk(v, 8'h10);
        chk({4'h0, gain_trim_code}, 8'h08);
        chk({4'h0, gain_trim_tenth_db}, 8'h00);
        chk(phase_delay_cycles, 8'h00);
        chk({input_kind_select, input_source_select, coupling_select, mic_swing_select,
            amp_rejection_mode, auto_gain_enable}, 8'h10);
    endtask

    // A pattern with mixed periods makes an off-by-one delay show up
    task run_delay(input logic [7:0] n, input int count);
        logic hist [0:299];
        wr(8'h4A, n);
        for (int i = 0; i < count; i++) begin
            hist[i] = i[0] ^ i[2] ^ i[5];
            @(posedge mclk);
            mod_tick <= 1'b1;
            ch3_mod_bit <= hist[i];
            @(posedge mclk);
            mod_tick <= 1'b0;
            #1;
            if (i >= n) chk({7'h0, ch3_mod_bit_delayed}, {7'h0, hist[i - n]});
        end
        ch3_mod_bit <= ~hist[count - 1];
        repeat (3) @(posedge mclk);
        #1;
        chk({7'h0, ch3_mod_bit_delayed}, {7'h0, hist[count - 1 - n]});
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [7:0] v;
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        mod_tick = 1'b0;
        ch3_mod_bit = 1'b0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        check_defaults();
        foreach (gain_vals[k]) begin
            wr(8'h49, {gain_vals[k], 4'h0});
            rd(8'h49, v);
            chk(v, {gain_vals[k], 4'h0});
            chk({4'h0, gain_trim_code}, {4'h0, gain_vals[k]});
            chk({4'h0, gain_trim_tenth_db}, {4'h0, gain_tenths[k]});
        end
        foreach (setup_vals[k]) begin
            wr(8'h4B, setup_vals[k]);
            rd(8'h4B, v);
            chk(v, setup_vals[k]);
            chk({input_kind_select, input_source_select, coupling_select, mic_swing_select,
                amp_rejection_mode, auto_gain_enable}, setup_vals[k]);
        end
        wr(8'h4A, 8'hFF);
        rd(8'h4A, v);
        chk(v, 8'hFF);
        wr(8'h4C, 8'h00);
        wr(8'h48, 8'hFF);
        rd(8'h48, v);
        chk(v, 8'h00);
        rd(8'h4B, v);
        chk(v, 8'h10);
        chk(phase_delay_cycles, 8'hFF);
        chk({4'h0, gain_trim_code}, 8'h05);
        run_delay(8'd0, 12);
        run_delay(8'd2, 10);
        run_delay(8'd3, 20);
        run_delay(8'd255, 262);
        wr(8'h4B, 8'h89);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(reg_rdata, 8'h00);
        chk({7'h0, ch3_mod_bit_delayed}, 8'h00);
        nrst <= 1'b1;
        check_defaults();
        conclude();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
